// [cmd_pkg.sv]
`default_nettype none

package cmd_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int CMD_LINES = 16;
    localparam int CMD_DW = 64;
    localparam int CMD_IDX_W = 6;
    localparam int CMD_LA_W = 30;
    localparam int CMD_CNT_W = 5;

    typedef logic [CMD_IDX_W-1:0] cmd_idx_t;
    typedef logic [CMD_DW-1:0] cmd_word_t;

    // ----------------------------------------------------------------
    // register indices (word addresses on the register port)
    // ----------------------------------------------------------------
    localparam cmd_idx_t CMD_IDX_WMAP_BASE = 6'h00;
    localparam cmd_idx_t CMD_IDX_RMAP_BASE = 6'h10;
    localparam cmd_idx_t CMD_IDX_CTRL = 6'h20;
    localparam cmd_idx_t CMD_IDX_STAT = 6'h21;

    // ----------------------------------------------------------------
    // write-map line word layout
    // ----------------------------------------------------------------
    localparam int CMD_W_PEND_BIT = 34;
    localparam int CMD_W_QUEUED_BIT = 33;
    localparam int CMD_W_RCONF_BIT = 32;
    localparam int CMD_LA_LSB = 0;

    // ----------------------------------------------------------------
    // read-map line word layout
    // ----------------------------------------------------------------
    localparam int CMD_R_PEND_BIT = 52;
    localparam int CMD_R_ISSUER_LSB = 49;
    localparam int CMD_R_TAG_LSB = 43;
    localparam int CMD_R_SWAP_BIT = 42;
    localparam int CMD_R_ZLEN_BIT = 41;
    localparam int CMD_R_TYPE_LSB = 39;
    localparam int CMD_R_COH_LSB = 37;
    localparam int CMD_R_QUEUED_BIT = 36;
    localparam int CMD_R_OUTST_LSB = 34;
    localparam int CMD_R_WCONF_BIT = 33;
    localparam int CMD_R_LATE_BIT = 32;

    // ----------------------------------------------------------------
    // control and status layout
    // ----------------------------------------------------------------
    localparam int CMD_CTRL_FREEZE_BIT = 0;
    localparam int CMD_CTRL_CLR_BIT = 1;
    localparam int CMD_ST_WCNT_LSB = 0;
    localparam int CMD_ST_RCNT_LSB = 8;
    localparam int CMD_ST_FROZEN_BIT = 16;
    localparam int CMD_ST_WRIGN_BIT = 17;
    localparam int CMD_ST_UNMAP_BIT = 18;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [CMD_LINES-1:0] CMD_PEND_RST = 16'h0000;
    localparam logic CMD_FREEZE_RST = 1'h0;
    localparam logic CMD_FLAG_RST = 1'h0;
    localparam cmd_word_t CMD_RDATA_RST = 64'h0;

endpackage

`default_nettype wire

// [cmd_wmap_word.sv]
`timescale 1ns/1ps
`default_nettype none

module cmd_wmap_word (
    // line state
    input wire logic pending,
    input wire logic entry_queued,
    input wire logic read_conflict,
    input wire logic [cmd_pkg::CMD_LA_W-1:0] line_addr,
    // packed register image
    output cmd_pkg::cmd_word_t word
);
    import cmd_pkg::*;

    // reserved bits read as zero
    always_comb begin
        word = '0;
        word[CMD_W_PEND_BIT] = pending;
        word[CMD_W_QUEUED_BIT] = entry_queued;
        word[CMD_W_RCONF_BIT] = read_conflict;
        word[CMD_LA_LSB +: CMD_LA_W] = line_addr;
    end

endmodule // cmd_wmap_word

`default_nettype wire

// [cmd_rmap_word.sv]
`timescale 1ns/1ps
`default_nettype none

module cmd_rmap_word (
    // line state
    input wire logic pending,
    input wire logic [2:0] issuer_id,
    input wire logic [5:0] txn_tag,
    input wire logic swap_bytes,
    input wire logic zero_length,
    input wire logic [1:0] txn_type,
    input wire logic [1:0] coh_resp,
    input wire logic entry_queued,
    input wire logic [1:0] outstanding_reads,
    input wire logic write_conflict,
    input wire logic late_write_conflict,
    input wire logic [cmd_pkg::CMD_LA_W-1:0] line_addr,
    // packed register image
    output cmd_pkg::cmd_word_t word
);
    import cmd_pkg::*;

    always_comb begin
        word = '0;
        word[CMD_R_PEND_BIT] = pending;
        word[CMD_R_ISSUER_LSB +: 3] = issuer_id;
        word[CMD_R_TAG_LSB +: 6] = txn_tag;
        word[CMD_R_SWAP_BIT] = swap_bytes;
        word[CMD_R_ZLEN_BIT] = zero_length;
        word[CMD_R_TYPE_LSB +: 2] = txn_type;
        word[CMD_R_COH_LSB +: 2] = coh_resp;
        word[CMD_R_QUEUED_BIT] = entry_queued;
        word[CMD_R_OUTST_LSB +: 2] = outstanding_reads;
        word[CMD_R_WCONF_BIT] = write_conflict;
        word[CMD_R_LATE_BIT] = late_write_conflict;
        word[CMD_LA_LSB +: CMD_LA_W] = line_addr;
    end

endmodule // cmd_rmap_word

`default_nettype wire

// [cmd_diag_bank.sv]
// Functional notes
// - sixteen read-only 64-bit registers, one per write-map line.
// - sixteen read-only 64-bit registers, one per read-map line.
// - write-map register shows the line's pending flag.
// - write-map register shows whether the entry sits in the write queue.
// - write-map register flags a conflict with a read-map entry.
// - read-map register shows the line's pending flag.
// - read-map register shows the 3-bit issuing master identifier.
// - read-map register shows the issuer's transaction tag.
// - read-map register flags byte-swapped read return.
// - read-map register flags a zero-length read request.
// - read-map register shows whether the entry sits in the read queue.
// - read-map register shows 2-bit count of reads outstanding in memory.
// - read-map register flags a conflict with a write-map entry.
// - read-map register flags a conflict arising after issue to memory.
// - bus signals carry their driving block's prefix; shared ones a common one.
`timescale 1ns/1ps
`default_nettype none

module cmd_diag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire cmd_pkg::cmd_idx_t reg_addr,
    input wire cmd_pkg::cmd_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output cmd_pkg::cmd_word_t cmd_rd_data,
    // write coherency map state, one bit or field per line
    input wire logic [15:0] wmap_pending,
    input wire logic [15:0] wmap_entry_queued,
    input wire logic [15:0] wmap_read_conflict,
    input wire logic [16*30-1:0] wmap_line_addr,
    // read coherency map state, one bit or field per line
    input wire logic [15:0] rmap_pending,
    input wire logic [16*3-1:0] rmap_issuer_id,
    input wire logic [16*6-1:0] rmap_txn_tag,
    input wire logic [15:0] rmap_swap_bytes,
    input wire logic [15:0] rmap_zero_length,
    input wire logic [16*2-1:0] rmap_txn_type,
    input wire logic [16*2-1:0] rmap_coh_resp,
    input wire logic [15:0] rmap_entry_queued,
    input wire logic [16*2-1:0] rmap_outstanding_reads,
    input wire logic [15:0] rmap_write_conflict,
    input wire logic [15:0] rmap_late_write_conflict,
    input wire logic [16*30-1:0] rmap_line_addr,
    // diagnostic state
    output logic cmd_map_frozen
);
    import cmd_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_wmap_idx(input cmd_idx_t idx);
        is_wmap_idx = (idx[5:4] == CMD_IDX_WMAP_BASE[5:4]);
    endfunction

    function automatic logic is_rmap_idx(input cmd_idx_t idx);
        is_rmap_idx = (idx[5:4] == CMD_IDX_RMAP_BASE[5:4]);
    endfunction

    function automatic logic [CMD_CNT_W-1:0] count_ones(
        input logic [CMD_LINES-1:0] v);
        logic [CMD_CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < CMD_LINES; i++) begin
            n = n + {{(CMD_CNT_W-1){1'b0}}, v[i]};
        end
        count_ones = n;
    endfunction

    // ----------------------------------------------------------------
    // map snapshot
    // ----------------------------------------------------------------
    // the snapshot follows the maps each cycle; freezing it lets software
    // read all 32 lines as one coherent picture, at the cost of showing
    // stale state until the freeze is released
    logic freeze_q;
    logic [15:0] w_pend_q;
    logic [15:0] w_queued_q;
    logic [15:0] w_rconf_q;
    logic [16*30-1:0] w_addr_q;
    logic [15:0] r_pend_q;
    logic [16*3-1:0] r_issuer_q;
    logic [16*6-1:0] r_tag_q;
    logic [15:0] r_swap_q;
    logic [15:0] r_zlen_q;
    logic [16*2-1:0] r_type_q;
    logic [16*2-1:0] r_coh_q;
    logic [15:0] r_queued_q;
    logic [16*2-1:0] r_outst_q;
    logic [15:0] r_wconf_q;
    logic [15:0] r_late_q;
    logic [16*30-1:0] r_addr_q;

    // ----------------------------------------------------------------
    // pending capture
    // ----------------------------------------------------------------
    // the snapshot follows the maps while this is high
    wire logic snap_en = ~freeze_q;

    // only the pending flags are reset; the fields beside them stay
    // undefined until the first edge at which the snapshot captures the maps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_pend_q <= CMD_PEND_RST;
            r_pend_q <= CMD_PEND_RST;
        end else if (snap_en) begin
            w_pend_q <= wmap_pending;
            r_pend_q <= rmap_pending;
        end
    end

    // ----------------------------------------------------------------
    // write-map capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (snap_en) begin
            w_queued_q <= wmap_entry_queued;
            w_rconf_q <= wmap_read_conflict;
        end
    end

    // addresses are not reset: a reset tree this wide buys nothing
    always_ff @(posedge clk) begin
        if (snap_en) begin
            w_addr_q <= wmap_line_addr;
        end
    end

    // ----------------------------------------------------------------
    // read-map capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (snap_en) begin
            r_issuer_q <= rmap_issuer_id;
            r_tag_q <= rmap_txn_tag;
            r_type_q <= rmap_txn_type;
            r_coh_q <= rmap_coh_resp;
        end
    end

    always_ff @(posedge clk) begin
        if (snap_en) begin
            r_swap_q <= rmap_swap_bytes;
            r_zlen_q <= rmap_zero_length;
        end
    end

    always_ff @(posedge clk) begin
        if (snap_en) begin
            r_queued_q <= rmap_entry_queued;
            r_outst_q <= rmap_outstanding_reads;
            r_wconf_q <= rmap_write_conflict;
            r_late_q <= rmap_late_write_conflict;
        end
    end

    always_ff @(posedge clk) begin
        if (snap_en) begin
            r_addr_q <= rmap_line_addr;
        end
    end

    // ----------------------------------------------------------------
    // per-line register images
    // ----------------------------------------------------------------
    cmd_word_t wmap_word [CMD_LINES];
    cmd_word_t rmap_word [CMD_LINES];

    for (genvar g = 0; g < CMD_LINES; g++) begin : g_line
        cmd_wmap_word u_wmap (
            .pending(w_pend_q[g]),
            .entry_queued(w_queued_q[g]),
            .read_conflict(w_rconf_q[g]),
            .line_addr(w_addr_q[g*CMD_LA_W +: CMD_LA_W]),
            .word(wmap_word[g])
        );
        cmd_rmap_word u_rmap (
            .pending(r_pend_q[g]),
            .issuer_id(r_issuer_q[g*3 +: 3]),
            .txn_tag(r_tag_q[g*6 +: 6]),
            .swap_bytes(r_swap_q[g]),
            .zero_length(r_zlen_q[g]),
            .txn_type(r_type_q[g*2 +: 2]),
            .coh_resp(r_coh_q[g*2 +: 2]),
            .entry_queued(r_queued_q[g]),
            .outstanding_reads(r_outst_q[g*2 +: 2]),
            .write_conflict(r_wconf_q[g]),
            .late_write_conflict(r_late_q[g]),
            .line_addr(r_addr_q[g*CMD_LA_W +: CMD_LA_W]),
            .word(rmap_word[g])
        );
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire logic [3:0] line_sel = reg_addr[3:0];
    wire logic hit_wmap = is_wmap_idx(reg_addr);
    wire logic hit_rmap = is_rmap_idx(reg_addr);
    wire logic hit_ctrl = (reg_addr == CMD_IDX_CTRL);
    wire logic hit_stat = (reg_addr == CMD_IDX_STAT);
    wire logic hit_diag = hit_wmap | hit_rmap;
    wire logic hit_any = hit_diag | hit_ctrl | hit_stat;
    wire logic ctrl_wr = reg_wr & hit_ctrl;
    // a write to a line register only leaves a trace in status
    wire logic diag_wr = reg_wr & hit_diag;
    wire logic unmap_acc = (reg_wr | reg_rd) & ~hit_any;
    wire logic flag_clr = ctrl_wr & reg_wdata[CMD_CTRL_CLR_BIT];

    // ----------------------------------------------------------------
    // control and sticky status
    // ----------------------------------------------------------------
    logic wr_ign_q;
    logic unmap_q;

    // the frozen output loads the same next value as the control bit,
    // so both change on one edge
    wire logic freeze_d =
        ctrl_wr ? reg_wdata[CMD_CTRL_FREEZE_BIT] : freeze_q;

    // a new event in the clearing cycle survives the clear
    wire logic wr_ign_d = diag_wr | (wr_ign_q & ~flag_clr);
    wire logic unmap_d = unmap_acc | (unmap_q & ~flag_clr);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            freeze_q <= CMD_FREEZE_RST;
        end else begin
            freeze_q <= freeze_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ign_q <= CMD_FLAG_RST;
        end else begin
            wr_ign_q <= wr_ign_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unmap_q <= CMD_FLAG_RST;
        end else begin
            unmap_q <= unmap_d;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire logic [CMD_CNT_W-1:0] w_count = count_ones(w_pend_q);
    wire logic [CMD_CNT_W-1:0] r_count = count_ones(r_pend_q);

    cmd_word_t ctrl_word;
    cmd_word_t stat_word;
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CMD_CTRL_FREEZE_BIT] = freeze_q;
        stat_word = '0;
        stat_word[CMD_ST_WCNT_LSB +: CMD_CNT_W] = w_count;
        stat_word[CMD_ST_RCNT_LSB +: CMD_CNT_W] = r_count;
        stat_word[CMD_ST_FROZEN_BIT] = freeze_q;
        stat_word[CMD_ST_WRIGN_BIT] = wr_ign_q;
        stat_word[CMD_ST_UNMAP_BIT] = unmap_q;
    end

    // selected line image of each map
    wire cmd_word_t w_line_word = wmap_word[line_sel];
    wire cmd_word_t r_line_word = rmap_word[line_sel];

    // reading has no side effect on the snapshot or the maps
    wire cmd_word_t rd_mux =
        hit_wmap ? w_line_word :
        hit_rmap ? r_line_word :
        hit_ctrl ? ctrl_word :
        hit_stat ? stat_word : CMD_RDATA_RST;

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    // data stand one cycle after the read strobe and read zero otherwise
    wire cmd_word_t rd_data_d = reg_rd ? rd_mux : CMD_RDATA_RST;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_rd_data <= CMD_RDATA_RST;
        end else begin
            cmd_rd_data <= rd_data_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_map_frozen <= CMD_FREEZE_RST;
        end else begin
            cmd_map_frozen <= freeze_d;
        end
    end

endmodule // cmd_diag_bank

`default_nettype wire

// [cmd_diag_bank_properties.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// read-back checker
// ------------------------------------------------------------
module cmd_diag_bank_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire cmd_pkg::cmd_idx_t reg_addr,
    input wire cmd_pkg::cmd_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire cmd_pkg::cmd_word_t cmd_rd_data,
    // write map state
    input wire logic [15:0] wmap_pending,
    input wire logic [15:0] wmap_entry_queued,
    input wire logic [15:0] wmap_read_conflict,
    input wire logic [479:0] wmap_line_addr,
    // read map state
    input wire logic [15:0] rmap_pending,
    input wire logic [47:0] rmap_issuer_id,
    input wire logic [95:0] rmap_txn_tag,
    input wire logic [15:0] rmap_swap_bytes,
    input wire logic [15:0] rmap_zero_length,
    input wire logic [31:0] rmap_txn_type,
    input wire logic [31:0] rmap_coh_resp,
    input wire logic [15:0] rmap_entry_queued,
    input wire logic [31:0] rmap_outstanding_reads,
    input wire logic [15:0] rmap_write_conflict,
    input wire logic [15:0] rmap_late_write_conflict,
    input wire logic [479:0] rmap_line_addr,
    // diagnostic state
    input wire logic cmd_map_frozen
);
    import cmd_pkg::*;

    logic [15:0] wp_q, wq_q, wc_q, rp_q, rs_q, rz_q, rq_q, rw_q, rl_q;
    logic [479:0] wa_q, ra_q;
    logic [47:0] ri_q;
    logic [95:0] rt_q;
    logic [31:0] ry_q, rc_q, ro_q;
    logic ok_q;
    logic [3:0] ln;
    logic w_rd, r_rd;
    cmd_word_t w_exp, r_exp;

    // map one edge late; frozen or just-reset reads are left to the bench
    always_ff @(posedge clk) begin
        {wp_q, wq_q, wc_q, wa_q} <= {wmap_pending, wmap_entry_queued,
            wmap_read_conflict, wmap_line_addr};
        {rp_q, ri_q, rt_q, rs_q, rz_q, ry_q, rc_q, rq_q, ro_q, rw_q, rl_q,
            ra_q} <= {rmap_pending, rmap_issuer_id, rmap_txn_tag,
            rmap_swap_bytes, rmap_zero_length, rmap_txn_type, rmap_coh_resp,
            rmap_entry_queued, rmap_outstanding_reads, rmap_write_conflict,
            rmap_late_write_conflict, rmap_line_addr};
        ok_q <= rst_n && !cmd_map_frozen;
    end

    assign ln = reg_addr[3:0];
    assign w_rd = reg_rd && ok_q && reg_addr[5:4] == 2'h0;
    assign r_rd = reg_rd && ok_q && reg_addr[5:4] == 2'h1;
    assign w_exp = {29'h0, wp_q[ln], wq_q[ln], wc_q[ln], 2'h0,
        wa_q[ln*30 +: 30]};
    assign r_exp = {11'h0, rp_q[ln], ri_q[ln*3 +: 3], rt_q[ln*6 +: 6],
        rs_q[ln], rz_q[ln], ry_q[ln*2 +: 2], rc_q[ln*2 +: 2], rq_q[ln],
        ro_q[ln*2 +: 2], rw_q[ln], rl_q[ln], 2'h0, ra_q[ln*30 +: 30]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_wmap_pend_bit: assert property (
        w_rd |=> cmd_rd_data[34] == $past(w_exp[34]))
        else $error("write map pending bit wrong");
    chk_wmap_flag_bits: assert property (
        w_rd |=> cmd_rd_data[33:32] == $past(w_exp[33:32]))
        else $error("write map queue or conflict bit wrong");
    chk_wmap_whole_word: assert property (
        w_rd |=> cmd_rd_data == $past(w_exp))
        else $error("write map word wrong");
    chk_rmap_pend_bit: assert property (
        r_rd |=> cmd_rd_data[52] == $past(r_exp[52]))
        else $error("read map pending bit wrong");
    chk_rmap_id_tag: assert property (
        r_rd ##1 1'b1 |-> cmd_rd_data[51:43] == $past(r_exp[51:43]))
        else $error("read map issuer or tag wrong");
    chk_rmap_flag_bits: assert property (
        r_rd |-> ##1 cmd_rd_data[42:32] == $past(r_exp[42:32]))
        else $error("read map flags wrong");
    chk_rmap_read_count: assert property (
        r_rd |=> cmd_rd_data[35:34] == $past(r_exp[35:34]))
        else $error("read map outstanding count wrong");
    chk_rmap_whole_word: assert property (
        r_rd |=> cmd_rd_data == $past(r_exp))
        else $error("read map word wrong");
    chk_idle_read_zero: assert property (
        !reg_rd |=> cmd_rd_data == 64'h0)
        else $error("read data outside answer cycle");
    chk_freeze_follows: assert property (
        reg_wr && reg_addr == CMD_IDX_CTRL |=>
        cmd_map_frozen == $past(reg_wdata[0]))
        else $error("freeze flag not taken");
    chk_freeze_holds: assert property (
        !(reg_wr && reg_addr == CMD_IDX_CTRL) |=> $stable(cmd_map_frozen))
        else $error("freeze flag moved");
endmodule // cmd_diag_bank_properties

bind cmd_diag_bank cmd_diag_bank_properties u_props (.*);

`default_nettype wire

// [cmd_diag_bank_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module cmd_diag_bank_tb_top;
    import cmd_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cmd_idx_t reg_addr = 6'h00;
    cmd_word_t reg_wdata = 64'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    cmd_word_t cmd_rd_data;
    logic cmd_map_frozen;
    logic [15:0] wmap_pending, wmap_entry_queued, wmap_read_conflict;
    logic [15:0] rmap_pending, rmap_swap_bytes, rmap_zero_length;
    logic [15:0] rmap_entry_queued, rmap_write_conflict;
    logic [15:0] rmap_late_write_conflict;
    logic [479:0] wmap_line_addr, rmap_line_addr;
    logic [47:0] rmap_issuer_id;
    logic [95:0] rmap_txn_tag;
    logic [31:0] rmap_txn_type, rmap_coh_resp, rmap_outstanding_reads;
    logic [1343:0] pool;
    cmd_word_t seed = 64'h49;
    cmd_word_t m;
    cmd_word_t exp_q[$];
    cmd_word_t saved[32];
    logic rd_seen = 1'b0;
    int mismatches = 0;
    int compares = 0;

    cmd_diag_bank dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .cmd_rd_data, .wmap_pending, .wmap_entry_queued,
        .wmap_read_conflict, .wmap_line_addr, .rmap_pending, .rmap_issuer_id,
        .rmap_txn_tag, .rmap_swap_bytes, .rmap_zero_length, .rmap_txn_type,
        .rmap_coh_resp, .rmap_entry_queued, .rmap_outstanding_reads,
        .rmap_write_conflict, .rmap_late_write_conflict, .rmap_line_addr,
        .cmd_map_frozen);

    initial forever #25 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic cmd_word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction

    // expected register image, built from the map inputs we drive
    function automatic cmd_word_t img(input int a);
        int k;
        k = a - 16;
        if (a < 16)
            return {29'h0, wmap_pending[a], wmap_entry_queued[a],
                wmap_read_conflict[a], 2'h0, wmap_line_addr[a*30 +: 30]};
        if (a < 32)
            return {11'h0, rmap_pending[k], rmap_issuer_id[k*3 +: 3],
                rmap_txn_tag[k*6 +: 6], rmap_swap_bytes[k],
                rmap_zero_length[k], rmap_txn_type[k*2 +: 2],
                rmap_coh_resp[k*2 +: 2], rmap_entry_queued[k],
                rmap_outstanding_reads[k*2 +: 2], rmap_write_conflict[k],
                rmap_late_write_conflict[k], 2'h0, rmap_line_addr[k*30 +: 30]};
        return 64'h0;
    endfunction

    task automatic load();
        {wmap_pending, wmap_entry_queued, wmap_read_conflict, wmap_line_addr,
            rmap_pending, rmap_issuer_id, rmap_txn_tag, rmap_swap_bytes,
            rmap_zero_length, rmap_txn_type, rmap_coh_resp, rmap_entry_queued,
            rmap_outstanding_reads, rmap_write_conflict,
            rmap_late_write_conflict, rmap_line_addr} <= pool;
    endtask

    task automatic scramble(input logic [15:0] pmask);
        for (int i = 0; i < 21; i++)
            pool[i*64 +: 64] = rnd();
        pool[1343 -: 16] &= pmask;
        pool[815 -: 16] &= pmask;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        load();
    endtask

    task automatic rd(input int a, input bit own = 1'b0,
                      input cmd_word_t e = 64'h0);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= cmd_idx_t'(a);
        exp_q.push_back(own ? e : img(a));
    endtask

    task automatic wr(input int a, input cmd_word_t d);
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= cmd_idx_t'(a);
        reg_wdata <= d;
    endtask

    task automatic chk(input string nm, input cmd_word_t e,
                       input cmd_word_t g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // result watcher: answer stands only in the cycle after a strobe
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rd_seen)
            chk("read data", exp_q.pop_front(), cmd_rd_data);
        else if (rst_n)
            chk("idle data", 64'h0, cmd_rd_data);
        rd_seen = reg_rd;
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        pool = '0;
        load();
        scramble(16'hffff);
        repeat (15) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= 6'h00;
        exp_q.push_back(img(0) & ~(64'h1 << 34));
        repeat (4) begin
            m = rnd();
            scramble(m[15:0]);
            for (int i = 0; i < 32; i++)
                rd(i);
            rd(8'h22);
            rd(8'h3f);
            for (int i = 0; i < 32; i++) begin
                wr(i, rnd());
                rd(i);
            end
        end
        // freeze: the snapshot must keep the values from before the write
        scramble(16'hffff);
        @(posedge clk);
        for (int i = 0; i < 32; i++)
            saved[i] = img(i);
        wr(CMD_IDX_CTRL, 64'h1);
        scramble(16'h5a5a);
        #1;
        chk("frozen flag", 64'h1, {63'h0, cmd_map_frozen});
        for (int i = 0; i < 32; i++)
            rd(i, 1'b1, saved[i]);
        rd(CMD_IDX_CTRL, 1'b1, 64'h1);
        wr(CMD_IDX_CTRL, 64'h0);
        scramble(16'ha5a5);
        for (int i = 0; i < 32; i++)
            rd(i);
        scramble(16'h0);
        rd(CMD_IDX_STAT, 1'b1, 64'h60000);
        wr(CMD_IDX_CTRL, 64'h2);
        rd(CMD_IDX_STAT, 1'b1, 64'h0);
        rd(CMD_IDX_CTRL, 1'b1, 64'h0);
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule // cmd_diag_bank_tb_top

`default_nettype wire
